// [rtl/ccpt_pkg.sv]
// Constants, register map and types for the capture/compare/PWM unit and period timer
//
// How it works
// - Period timer counts to limit, wraps to zero
// - Period limit read/write, all ones after reset
// - Period match pulse goes to serial port
// - One 16-bit capture, compare or duty register
// - Value halves and control are read/write bytes
// - Capture/compare use general timer, PWM period timer
// - Mode zero turns unit off, clears state
// - Capture on falling, rising, 4th, 16th edge
// - Compare match sets or clears pin, flags
// - Software compare only flags, pin unchanged
// - Special event flags, clears timer, starts conversion
// - PWM duty: low byte plus two control bits
// - Control bits 7 and 6 read zero
// - PWM units share period and update instant
// - Prescaler 1:1, 1:4 or 1:16
// - Postscaler 1:1 to 1:16 sets match flag
// - Count or control write clears pre/postscaler
// - Period timer gives PWM on-time and period
package ccpt_pkg;

	// ************************************************************
	// Register map (word index, byte address is four times it)
	// ************************************************************
	localparam int unsigned ADDR_W          = 12;
	localparam int unsigned IDX_W           = 8;
	localparam logic [IDX_W-1:0] IDX_INT_CTRL     = 8'h0b;
	localparam logic [IDX_W-1:0] IDX_INT_CTRL_ALT = 8'h8b;
	localparam logic [IDX_W-1:0] IDX_PERI_FLAGS   = 8'h0c;
	localparam logic [IDX_W-1:0] IDX_PERI_ENABLES = 8'h8c;
	localparam logic [IDX_W-1:0] IDX_TMR_COUNT    = 8'h11;
	localparam logic [IDX_W-1:0] IDX_TMR_CTRL     = 8'h12;
	localparam logic [IDX_W-1:0] IDX_CC_LOW       = 8'h15;
	localparam logic [IDX_W-1:0] IDX_CC_HIGH      = 8'h16;
	localparam logic [IDX_W-1:0] IDX_CC_CTRL      = 8'h17;
	localparam logic [IDX_W-1:0] IDX_PERIOD_LIMIT = 8'h92;

	// ************************************************************
	// Reset values, field masks and bit positions
	// ************************************************************
	localparam logic [7:0] RST_ZERO8        = 8'h00;
	localparam logic [7:0] RST_PERIOD_LIMIT = 8'hff;
	localparam logic [7:0] INT_CTRL_MASK    = 8'hc0;
	localparam logic [7:0] PIE_MASK         = 8'h06;
	localparam int unsigned PIR_CC_BIT      = 2;
	localparam int unsigned PIR_PM_BIT      = 1;

	// ************************************************************
	// Mode codes, prescaler codes and terminal counts
	// ************************************************************
	localparam logic [3:0] MODE_OFF        = 4'h0;
	localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET    = 4'h8;
	localparam logic [3:0] MODE_CMP_CLR    = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT   = 4'ha;
	localparam logic [3:0] MODE_CMP_SPEC   = 4'hb;
	localparam logic [1:0] PRE_SEL_1       = 2'h0;
	localparam logic [1:0] PRE_SEL_4       = 2'h1;
	localparam logic [3:0] PRE_TC_1        = 4'h0;
	localparam logic [3:0] PRE_TC_4        = 4'h3;
	localparam logic [3:0] PRE_TC_16       = 4'hf;
	localparam logic [3:0] CAP_TC_1        = 4'h0;
	localparam logic [3:0] CAP_TC_4        = 4'h3;
	localparam logic [3:0] CAP_TC_16       = 4'hf;
	localparam logic [1:0] AXI_OKAY        = 2'h0;
	localparam logic [1:0] AXI_SLVERR      = 2'h2;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {CK_OFF, CK_CAPTURE, CK_COMPARE, CK_PWM} ccpt_kind_e;

	typedef struct packed {
		logic [3:0] postscale_select;
		logic       period_timer_on;
		logic [1:0] prescale_select;
	} ccpt_tctl_s;

	typedef struct packed {
		logic [1:0] duty_low_bits;
		logic [3:0] unit_mode_select;
	} ccpt_cctl_s;

endpackage

// [rtl/ccpt_top.sv]
// Capture/compare/PWM unit with its 8-bit period timer and AXI4-Lite register slave
`timescale 1ns/1ns
module ccpt_top
	import ccpt_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_B,
	input  wire logic              CE,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	input  wire logic [15:0]       GTMR_VALUE,
	input  wire logic              ADC_ENABLED,
	input  wire logic              CCP_PIN_IN,
	output logic                   CCP_PIN_OUT,
	output logic                   CCP_PIN_OE,
	output logic                   PERIOD_MATCH,
	output logic                   GTMR_CLEAR,
	output logic                   ADC_START
);

	// ************************************************************
	// Decoding helpers
	// ************************************************************
	// Word index of a byte address; upper address bits must be clear to hit
	function automatic logic [IDX_W:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = {(addr[ADDR_W-1:IDX_W+2] == '0), addr[IDX_W+1:2]};
	endfunction

	// Is an index one of the implemented registers
	function automatic logic idx_mapped(input logic [IDX_W:0] sel);
		idx_mapped = sel[IDX_W] && (sel[IDX_W-1:0] == IDX_INT_CTRL
			|| sel[IDX_W-1:0] == IDX_INT_CTRL_ALT || sel[IDX_W-1:0] == IDX_PERI_FLAGS
			|| sel[IDX_W-1:0] == IDX_PERI_ENABLES || sel[IDX_W-1:0] == IDX_TMR_COUNT
			|| sel[IDX_W-1:0] == IDX_TMR_CTRL || sel[IDX_W-1:0] == IDX_CC_LOW
			|| sel[IDX_W-1:0] == IDX_CC_HIGH || sel[IDX_W-1:0] == IDX_CC_CTRL
			|| sel[IDX_W-1:0] == IDX_PERIOD_LIMIT);
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	logic              aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
	logic              arready_ff, rvalid_ff;
	logic [1:0]        bresp_ff, rresp_ff;
	logic [ADDR_W-1:0] aw_addr_ff;
	logic [7:0]        w_data_ff;
	logic              w_lane0_ff;
	logic [31:0]       rdata_ff;
	logic [7:0]        int_ctrl_ff, pie_ff, tmr_ff, limit_ff;
	logic              flag_cc_ff, flag_pm_ff;
	ccpt_tctl_s        tctl_ff;
	ccpt_cctl_s        cctl_ff;
	logic [15:0]       cc_val_ff;
	logic [3:0]        pre_cnt_ff, post_cnt_ff, cap_cnt_ff;
	logic              cmp_hit_ff, pin_ff, oe_ff, pm_out_ff, gclr_ff, adc_ff;
	logic [9:0]        duty_ff;
	logic              pin_s1_ff, pin_s2_ff, pin_s3_ff;

	// ************************************************************
	// Bus handshake terms
	// ************************************************************
	logic             aw_fire, w_fire, ar_fire, wr_do;
	logic             nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_rvalid;
	logic [IDX_W:0]   wr_sel, rd_sel;
	logic             wr_en, wr_int, wr_pir, wr_pie, wr_tmr, wr_tctl, wr_lim;
	logic             wr_ccl, wr_cch, wr_cctl;
	assign aw_fire     = S_AXI_AWVALID && awready_ff;
	assign w_fire      = S_AXI_WVALID && wready_ff;
	assign ar_fire     = S_AXI_ARVALID && arready_ff;
	assign wr_do       = aw_held_ff && w_held_ff && !bvalid_ff;
	assign nxt_aw_held = aw_fire || (aw_held_ff && !wr_do);
	assign nxt_w_held  = w_fire || (w_held_ff && !wr_do);
	assign nxt_bvalid  = wr_do || (bvalid_ff && !S_AXI_BREADY);
	assign nxt_rvalid  = ar_fire || (rvalid_ff && !S_AXI_RREADY);

	// Write strobes per register; only byte lane 0 carries data
	assign wr_sel  = reg_index(aw_addr_ff);
	assign wr_en   = wr_do && w_lane0_ff && idx_mapped(wr_sel);
	assign wr_int  = wr_en && (wr_sel[IDX_W-1:0] == IDX_INT_CTRL
		|| wr_sel[IDX_W-1:0] == IDX_INT_CTRL_ALT);
	assign wr_pir  = wr_en && wr_sel[IDX_W-1:0] == IDX_PERI_FLAGS;
	assign wr_pie  = wr_en && wr_sel[IDX_W-1:0] == IDX_PERI_ENABLES;
	assign wr_tmr  = wr_en && wr_sel[IDX_W-1:0] == IDX_TMR_COUNT;
	assign wr_tctl = wr_en && wr_sel[IDX_W-1:0] == IDX_TMR_CTRL;
	assign wr_lim  = wr_en && wr_sel[IDX_W-1:0] == IDX_PERIOD_LIMIT;
	assign wr_ccl  = wr_en && wr_sel[IDX_W-1:0] == IDX_CC_LOW;
	assign wr_cch  = wr_en && wr_sel[IDX_W-1:0] == IDX_CC_HIGH;
	assign wr_cctl = wr_en && wr_sel[IDX_W-1:0] == IDX_CC_CTRL;

	// ************************************************************
	// Read mux
	// ************************************************************
	logic [7:0] rd_byte, pir_byte;
	assign rd_sel   = reg_index(S_AXI_ARADDR);
	assign pir_byte = (8'(flag_cc_ff) << PIR_CC_BIT) | (8'(flag_pm_ff) << PIR_PM_BIT);
	assign rd_byte  =
		(rd_sel[IDX_W-1:0] == IDX_INT_CTRL)     ? int_ctrl_ff :
		(rd_sel[IDX_W-1:0] == IDX_INT_CTRL_ALT) ? int_ctrl_ff :
		(rd_sel[IDX_W-1:0] == IDX_PERI_FLAGS)   ? pir_byte :
		(rd_sel[IDX_W-1:0] == IDX_PERI_ENABLES) ? pie_ff :
		(rd_sel[IDX_W-1:0] == IDX_TMR_COUNT)    ? tmr_ff :
		(rd_sel[IDX_W-1:0] == IDX_TMR_CTRL)     ? {1'b0, tctl_ff} :
		(rd_sel[IDX_W-1:0] == IDX_CC_LOW)       ? cc_val_ff[7:0] :
		(rd_sel[IDX_W-1:0] == IDX_CC_HIGH)      ? cc_val_ff[15:8] :
		(rd_sel[IDX_W-1:0] == IDX_CC_CTRL)      ? {2'b00, cctl_ff} :
		(rd_sel[IDX_W-1:0] == IDX_PERIOD_LIMIT) ? limit_ff : RST_ZERO8;

	// ************************************************************
	// Period timer, prescaler and postscaler
	// ************************************************************
	logic [3:0] pre_tc;
	logic       tick, wrap, post_hit, pre_clr;
	logic [1:0] ext2;
	assign pre_tc   = (tctl_ff.prescale_select == PRE_SEL_1) ? PRE_TC_1 :
		(tctl_ff.prescale_select == PRE_SEL_4) ? PRE_TC_4 : PRE_TC_16;
	assign tick     = tctl_ff.period_timer_on && (pre_cnt_ff == pre_tc);
	assign wrap     = tick && (tmr_ff == limit_ff) && !wr_tmr;
	assign post_hit = wrap && (post_cnt_ff == tctl_ff.postscale_select);
	assign pre_clr  = wr_tmr || wr_tctl;
	// Two extra low bits of PWM time come from the prescaler
	assign ext2     = (tctl_ff.prescale_select == PRE_SEL_1) ? 2'b00 :
		(tctl_ff.prescale_select == PRE_SEL_4) ? pre_cnt_ff[1:0] : pre_cnt_ff[3:2];

	// ************************************************************
	// Unit mode decode and events
	// ************************************************************
	ccpt_kind_e kind;
	always_comb begin
		case (cctl_ff.unit_mode_select[3:2])
			2'b01:   kind = CK_CAPTURE;
			2'b10:   kind = CK_COMPARE;
			2'b11:   kind = CK_PWM;
			default: kind = CK_OFF;
		endcase
	end

	logic [3:0] mode, cap_tc;
	logic       rise, fall, cap_edge, cap_event, cmp_eq, cmp_event, special;
	logic [9:0] duty_req;
	logic       duty_reached;
	assign mode      = cctl_ff.unit_mode_select;
	// Edges are taken from the second and third stage, never the first
	assign rise      = pin_s2_ff && !pin_s3_ff;
	assign fall      = !pin_s2_ff && pin_s3_ff;
	assign cap_edge  = (kind == CK_CAPTURE) && ((mode == MODE_CAP_FALL) ? fall : rise);
	assign cap_tc    = (mode == MODE_CAP_RISE4) ? CAP_TC_4 :
		(mode == MODE_CAP_RISE16) ? CAP_TC_16 : CAP_TC_1;
	assign cap_event = cap_edge && (cap_cnt_ff == cap_tc);
	// Compare runs against the general timer; one event per entry into match
	assign cmp_eq    = (kind == CK_COMPARE) && (GTMR_VALUE == cc_val_ff);
	assign cmp_event = cmp_eq && !cmp_hit_ff;
	assign special   = cmp_event && (mode == MODE_CMP_SPEC);
	assign duty_req  = {cc_val_ff[7:0], cctl_ff.duty_low_bits};
	assign duty_reached = ({tmr_ff, ext2} >= duty_ff);

	// ************************************************************
	// Next values
	// ************************************************************
	logic [7:0]  nxt_tmr;
	logic [3:0]  nxt_pre, nxt_post, nxt_cap_cnt;
	logic        nxt_flag_cc, nxt_flag_pm, nxt_pin;
	logic [15:0] nxt_cc_val;
	assign nxt_tmr  = wr_tmr ? w_data_ff : wrap ? RST_ZERO8 :
		tick ? tmr_ff + 8'h01 : tmr_ff;
	assign nxt_pre  = pre_clr ? '0 : !tctl_ff.period_timer_on ? pre_cnt_ff :
		(pre_cnt_ff == pre_tc) ? '0 : pre_cnt_ff + 4'h1;
	assign nxt_post = pre_clr ? '0 : post_hit ? '0 :
		wrap ? post_cnt_ff + 4'h1 : post_cnt_ff;
	// Hardware set wins over a software write in the same cycle
	assign nxt_flag_pm = post_hit || (wr_pir ? w_data_ff[PIR_PM_BIT] : flag_pm_ff);
	assign nxt_flag_cc = cap_event || cmp_event
		|| (wr_pir ? w_data_ff[PIR_CC_BIT] : flag_cc_ff);
	assign nxt_cap_cnt = (kind != CK_CAPTURE || cap_event) ? '0 :
		cap_edge ? cap_cnt_ff + 4'h1 : cap_cnt_ff;
	// A capture beats a software write to the value in the same cycle
	assign nxt_cc_val = cap_event ? GTMR_VALUE :
		{wr_cch ? w_data_ff : cc_val_ff[15:8], wr_ccl ? w_data_ff : cc_val_ff[7:0]};
	// Pin: compare actions, PWM on at period start and off at duty
	assign nxt_pin =
		(kind == CK_COMPARE) ? ((cmp_event && mode == MODE_CMP_SET) ? 1'b1 :
			(cmp_event && mode == MODE_CMP_CLR) ? 1'b0 : pin_ff) :
		(kind == CK_PWM) ? (wrap ? (duty_req != 10'h000) :
			(duty_reached ? 1'b0 : pin_ff)) : 1'b0;

	// ************************************************************
	// Flip-flops
	// ************************************************************
	// Bus slave; ready flags follow the held state so each channel takes one item
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			{aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff} <= '0;
			{arready_ff, rvalid_ff, w_lane0_ff} <= '0;
			{bresp_ff, rresp_ff} <= '0;
			aw_addr_ff <= '0;
			w_data_ff  <= RST_ZERO8;
			rdata_ff   <= '0;
		end else if (CE) begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff  <= nxt_w_held;
			awready_ff <= !nxt_aw_held;
			wready_ff  <= !nxt_w_held;
			bvalid_ff  <= nxt_bvalid;
			rvalid_ff  <= nxt_rvalid;
			arready_ff <= !nxt_rvalid;
			if (aw_fire) aw_addr_ff <= S_AXI_AWADDR;
			if (w_fire) begin
				w_data_ff  <= S_AXI_WDATA[7:0];
				w_lane0_ff <= S_AXI_WSTRB[0];
			end
			if (wr_do) bresp_ff <= idx_mapped(wr_sel) ? AXI_OKAY : AXI_SLVERR;
			if (ar_fire) begin
				rdata_ff <= {24'h000000, rd_byte};
				rresp_ff <= idx_mapped(rd_sel) ? AXI_OKAY : AXI_SLVERR;
			end
		end
	end

	// Pin synchroniser, two stages plus one for edge history
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			{pin_s1_ff, pin_s2_ff, pin_s3_ff} <= '0;
		end else if (CE) begin
			{pin_s1_ff, pin_s2_ff, pin_s3_ff} <= {CCP_PIN_IN, pin_s1_ff, pin_s2_ff};
		end
	end

	// Software registers and period timer
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			{int_ctrl_ff, pie_ff, tmr_ff} <= {RST_ZERO8, RST_ZERO8, RST_ZERO8};
			limit_ff <= RST_PERIOD_LIMIT;
			{tctl_ff, cctl_ff, cc_val_ff} <= '0;
			{pre_cnt_ff, post_cnt_ff, flag_pm_ff, flag_cc_ff} <= '0;
		end else if (CE) begin
			if (wr_int) int_ctrl_ff <= w_data_ff & INT_CTRL_MASK;
			if (wr_pie) pie_ff <= w_data_ff & PIE_MASK;
			if (wr_tctl) tctl_ff <= w_data_ff[6:0];
			if (wr_cctl) cctl_ff <= w_data_ff[5:0];
			if (wr_lim) limit_ff <= w_data_ff;
			tmr_ff      <= nxt_tmr;
			pre_cnt_ff  <= nxt_pre;
			post_cnt_ff <= nxt_post;
			flag_pm_ff  <= nxt_flag_pm;
			flag_cc_ff  <= nxt_flag_cc;
			cc_val_ff   <= nxt_cc_val;
		end
	end

	// Unit state and pin-side outputs
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			{cap_cnt_ff, cmp_hit_ff, pin_ff, oe_ff} <= '0;
			{pm_out_ff, gclr_ff, adc_ff} <= '0;
			duty_ff <= '0;
		end else if (CE) begin
			cap_cnt_ff <= nxt_cap_cnt;
			cmp_hit_ff <= cmp_eq;
			pin_ff     <= nxt_pin;
			oe_ff      <= (kind == CK_COMPARE) || (kind == CK_PWM);
			pm_out_ff  <= wrap;
			gclr_ff    <= special;
			adc_ff     <= special && ADC_ENABLED;
			// Duty latched only at the period boundary, shared by all PWM users
			if (wrap) duty_ff <= duty_req;
		end
	end

	assign S_AXI_AWREADY = awready_ff;
	assign S_AXI_WREADY  = wready_ff;
	assign S_AXI_BVALID  = bvalid_ff;
	assign S_AXI_BRESP   = bresp_ff;
	assign S_AXI_ARREADY = arready_ff;
	assign S_AXI_RVALID  = rvalid_ff;
	assign S_AXI_RDATA   = rdata_ff;
	assign S_AXI_RRESP   = rresp_ff;
	assign CCP_PIN_OUT   = pin_ff;
	assign CCP_PIN_OE    = oe_ff;
	assign PERIOD_MATCH  = pm_out_ff;
	assign GTMR_CLEAR    = gclr_ff;
	assign ADC_START     = adc_ff;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb_main @(posedge CLK); endclocking
	default disable iff (!RST_B);

	sequence s_special_hit;
		CE && cmp_event && mode == MODE_CMP_SPEC;
	endsequence
	sequence s_special_effect;
		GTMR_CLEAR && flag_cc_ff && (ADC_START == $past(ADC_ENABLED));
	endsequence

	a_timer_wrap: assert property (CE && tick && tmr_ff == limit_ff && !wr_tmr |=> tmr_ff == 8'h00)
		else $error("period timer did not wrap to zero");
	a_match_out_zero: assert property (PERIOD_MATCH |-> tmr_ff == 8'h00)
		else $error("period match pulse without zero count");
	a_ctrl_read: assert property (CE && ar_fire && rd_sel[IDX_W-1:0] == IDX_CC_CTRL && rd_sel[IDX_W]
		|=> S_AXI_RDATA[7:6] == 2'b00 && S_AXI_RDATA[5:0] == $past(cctl_ff))
		else $error("control read shows wrong bits");
	a_cmp_set_pin: assert property (CE && cmp_event && mode == MODE_CMP_SET
		|=> CCP_PIN_OUT && flag_cc_ff)
		else $error("set-on-match did not raise pin and flag");
	a_cmp_soft_pin: assert property (CE && cmp_event && mode == MODE_CMP_SOFT
		|=> $stable(CCP_PIN_OUT) && flag_cc_ff)
		else $error("software compare changed pin");
	a_special_event: assert property (s_special_hit |=> s_special_effect)
		else $error("special event effects missing");
	a_capture_copy: assert property (CE && cap_event |=> cc_val_ff == $past(GTMR_VALUE) && flag_cc_ff)
		else $error("capture did not copy general timer");
	a_off_clears: assert property (CE && kind == CK_OFF |=> !CCP_PIN_OUT && cap_cnt_ff == 4'h0)
		else $error("off mode left state behind");
	a_pwm_start: assert property (CE && kind == CK_PWM && wrap && duty_req != 10'h000
		|=> CCP_PIN_OUT && duty_ff == $past(duty_req))
		else $error("PWM period start did not raise pin");

endmodule // ccpt_top

// [tb/ccpt_pin_model.sv]
// Behavioural model of the external signal on the unit's pin
`timescale 1ns/1ns
module ccpt_pin_model (
	input  wire logic clk,
	output logic      pin
);
	// ********************
	// Pin pulse generator
	// ********************
	initial begin
		pin = 1'b0;
	end
	// Full pulses, each level held long enough for the synchroniser
	task automatic pulse(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk);
			pin <= 1'b1;
			repeat (4) @(posedge clk);
			pin <= 1'b0;
		end
	endtask
endmodule // ccpt_pin_model

// [tb/tb_top.sv]
// Self-checking bench for the capture/compare/PWM unit and period timer
`timescale 1ns/1ns
module tb_top
	import ccpt_pkg::*;
;
	logic        clk, rst_b, awv, wv, bready, arv, rready, adc_en;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rd;
	logic [15:0] gtmr, v;
	logic [7:0]  d;
	logic [1:0]  rsp;
	wire         awrdy, wrdy, bvalid, arrdy, rvalid, pin_in, pin_out, pin_oe, pmatch, gclr, adcst;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          fails, check_count, cyc, n, lim, gcnt, acnt, g0, a0;
	logic [7:0]  ridx [6] = '{IDX_TMR_COUNT, IDX_TMR_CTRL, IDX_CC_CTRL, IDX_PERI_FLAGS,
		IDX_PERI_ENABLES, IDX_PERIOD_LIMIT};
	logic [7:0]  widx [4] = '{IDX_CC_LOW, IDX_CC_HIGH, IDX_PERIOD_LIMIT, IDX_TMR_COUNT};
	ccpt_top DUT (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .GTMR_VALUE(gtmr), .ADC_ENABLED(adc_en), .CCP_PIN_IN(pin_in),
		.CCP_PIN_OUT(pin_out), .CCP_PIN_OE(pin_oe), .PERIOD_MATCH(pmatch), .GTMR_CLEAR(gclr),
		.ADC_START(adcst));
	ccpt_pin_model PM (.clk(clk), .pin(pin_in));
	// *******************
	// Clock, bus helpers
	// *******************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang guard; one-cycle pulses are counted here so none is missed
	always @(posedge clk) begin
		cyc++;
		gcnt += gclr;
		acnt += adcst;
		if (cyc == 30000) begin
			fails++;
			final_report();
		end
	end
	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [7:0] dat);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, dat};
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awrdy) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while ((awv && !awrdy) || (wv && !wrdy));
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [11:0] a);
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		do @(posedge clk); while (!arrdy);
		arv <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rd16();
		rdr(ad(IDX_CC_HIGH));
		v[15:8] = rd[7:0];
		rdr(ad(IDX_CC_LOW));
		v[7:0] = rd[7:0];
	endtask
	// Cycles between two period-match pulses, bounded
	task automatic period(output int cnt);
		int k;
		k = 0;
		do @(posedge clk); while (!pmatch && ++k < 2000);
		cnt = 0;
		do begin
			@(posedge clk);
			cnt++;
		end while (!pmatch && cnt < 2000);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// *******************
	// Test sequence
	// *******************
	initial begin
		{rst_b, awv, wv, bready, arv, rready, adc_en} = '0;
		{awaddr, araddr, wdata, gtmr} = '0;
		void'($urandom(32'h0ea38696));
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		foreach (ridx[i]) begin
			rdr(ad(ridx[i]));
			check("reset value", rd, (ridx[i] == IDX_PERIOD_LIMIT) ? 32'hff : 32'h0);
			check("read response", rsp, AXI_OKAY);
		end
		foreach (widx[i]) begin
			d = 8'($urandom);
			wr(ad(widx[i]), d);
			rdr(ad(widx[i]));
			check("register readback", rd, {24'h0, d});
		end
		wr(ad(IDX_CC_CTRL), 8'hff);
		rdr(ad(IDX_CC_CTRL));
		check("control readback", rd, 32'h3f);
		wr(12'h3fc, 8'h5a);
		check("unmapped write", rsp, AXI_SLVERR);
		$display("test registers done");
		// Period length at 1:1 then 1:4, then PWM with the prescaler back at 1:1
		lim = 2 + $urandom_range(7);
		wr(ad(IDX_PERIOD_LIMIT), 8'(lim));
		for (int p = 0; p < 2; p++) begin
			wr(ad(IDX_TMR_CTRL), p ? 8'h05 : 8'h04);
			period(n);
			check("period", n, (lim + 1) << (2 * p));
		end
		rdr(ad(IDX_PERI_FLAGS));
		check("match flag", rd[PIR_PM_BIT], 1'b1);
		d = 8'(1 + $urandom_range(lim - 2));
		wr(ad(IDX_TMR_CTRL), 8'h04);
		wr(ad(IDX_CC_LOW), d);
		wr(ad(IDX_CC_CTRL), 8'h1c);
		repeat (3 * lim + 6) @(posedge clk);
		n = 0;
		repeat (lim + 1) begin
			@(posedge clk);
			n += pin_out;
		end
		// Duty 4d+1 at 1:1 ends once count passes d; registered pin adds one cycle
		check("pwm high time", n, d + 2);
		wr(ad(IDX_CC_CTRL), 8'h00);
		repeat (2) @(posedge clk);
		check("off drive", pin_oe, 1'b0);
		$display("test timer and pwm done");
		// Each capture mode: no capture one edge early, capture on the last
		for (int m = 4; m < 8; m++) begin
			n = (m < 6) ? 1 : (m == 6) ? 4 : 16;
			wr(ad(IDX_CC_CTRL), 8'h00);
			wr(ad(IDX_CC_LOW), 8'h00);
			wr(ad(IDX_CC_HIGH), 8'h00);
			wr(ad(IDX_PERI_FLAGS), 8'h00);
			wr(ad(IDX_CC_CTRL), 8'(m));
			gtmr <= 16'($urandom);
			PM.pulse(n - 1);
			rd16();
			check("early capture", v, 16'h0);
			PM.pulse(1);
			repeat (4) @(posedge clk);
			rd16();
			check("capture value", v, gtmr);
			rdr(ad(IDX_PERI_FLAGS));
			check("capture flag", rd[PIR_CC_BIT], 1'b1);
		end
		$display("test capture done");
		// Each compare action; special event last, as software should pick it
		for (int m = 8; m < 12; m++) begin
			v = 16'(1 + $urandom_range(16'hfffe));
			gtmr <= 16'h0;
			adc_en <= (m == 11) | 1'($urandom);
			wr(ad(IDX_CC_CTRL), 8'h00);
			wr(ad(IDX_CC_LOW), v[7:0]);
			wr(ad(IDX_CC_HIGH), v[15:8]);
			wr(ad(IDX_PERI_FLAGS), 8'h00);
			wr(ad(IDX_CC_CTRL), 8'(m));
			d[0] = pin_out;
			g0 = gcnt;
			a0 = acnt;
			gtmr <= v;
			repeat (4) @(posedge clk);
			check("compare pin", pin_out, (m == 8) ? 1'b1 : (m == 9) ? 1'b0 : d[0]);
			check("timer clear", gcnt - g0, m == 11);
			check("conversion start", acnt - a0, m == 11 && adc_en);
			rdr(ad(IDX_PERI_FLAGS));
			check("compare flag", rd[PIR_CC_BIT], 1'b1);
		end
		$display("test compare done");
		final_report();
	end
endmodule // tb_top
